// *** core/pcrb_host.sv ***
// Host sequencer that reads status registers and configuration frames over the parallel configuration port
//
// Contract
// - Send command packets in write direction, then turn the port to read.
// - Chip select goes high before the direction changes, low again after.
// - Select and direction change relative to config_clock; device registers them.
// - Session opens: all-ones, width sync, width detect, all-ones, sync word.
// - At least one no-operation follows the sync word before any read header.
// - Status read: header 2800E001, two no-operations, then turn to read.
// - After reading: write direction, command header, desynchronize code, two no-operations.
// - Other registers: change address field and word count of the read header.
// - Memory read: shutdown code plus no-op, reset-CRC code plus no-op.
// - Five no-operations let shutdown finish; device drives done low meanwhile.
// - Then read-config code plus no-op and frame address write, normally zero.
// - Zero-word frame readout read, then type 2 header of words times frames+1.
// - Thirty-two no-operations flush the packet buffer before turning to read.
// - Finish: no-op, start, reset-CRC, desynchronize, 64 bits of no-ops, until done.
// - Turn to read just before the read words and back right after them.
`timescale 1ns/100ps
`include "pcrb_params.svh"

module pcrb_host
   import pcrb_pkg::*;
#(
   parameter logic [15:0] WORDS_PER_FRAME = 16'd101,
   parameter logic [10:0] FRAME_COUNT = 11'd1,
   parameter logic [31:0] START_FRAME_ADDR = 32'h00000000,
   parameter logic [3:0] READ_DUMMY_WORDS = 4'd1
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic status_req_i,
   input wire logic frame_req_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [10:0] reg_words_i,
   output logic busy_o,
   output logic finished_o,
   output logic done_low_seen_o,
   output logic [31:0] rd_data_o,
   output logic rd_last_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic config_clock_o,
   output logic chip_select_n_o,
   output logic read_write_select_o,
   output logic [31:0] data_o,
   output logic data_oe_o,
   input wire logic [31:0] data_i,
   input wire logic done_i
);

   // ***********************************************************
   // Derived counts
   // ***********************************************************
   localparam logic [26:0] FRAME_READ_WORDS =
      27'(WORDS_PER_FRAME * (27'(FRAME_COUNT) + 27'd1));
   localparam logic [26:0] READ_SKIP = `PCRB_READ_LATENCY + 27'(READ_DUMMY_WORDS);
   localparam int CFG_CLK_NS = `PCRB_CORE_CLK_NS * `PCRB_CFG_CLK_DIV;

   // ***********************************************************
   // Header builders
   // ***********************************************************
   function automatic logic [31:0] t1_read_hdr(input logic [4:0] addr, input logic [10:0] words);
      t1_read_hdr = {`PCRB_T1_TYPE, `PCRB_OP_READ, 9'h000, addr, 2'h0, words};
   endfunction : t1_read_hdr

   function automatic logic [31:0] t2_read_hdr(input logic [26:0] words);
      t2_read_hdr = {`PCRB_T2_TYPE, `PCRB_OP_READ, words};
   endfunction : t2_read_hdr

   function automatic pcrb_step_t wr(input logic [31:0] word);
      wr = '{op: PCRB_OP_WRITE, word: word, count: 27'd1};
   endfunction : wr

   function automatic pcrb_step_t ctl(input pcrb_op_t op, input logic [26:0] count);
      ctl = '{op: op, word: `PCRB_NOOP_WORD, count: count};
   endfunction : ctl

   // ***********************************************************
   // Command scripts
   // ***********************************************************
   function automatic pcrb_step_t script(input logic frame, input logic [5:0] idx,
                                         input logic [4:0] addr, input logic [10:0] words);
      script = ctl(PCRB_OP_END, 27'd1);
      unique case (idx)
         6'd0: script = wr(`PCRB_DUMMY_WORD);
         6'd1: script = wr(`PCRB_WIDTH_SYNC_WORD);
         6'd2: script = wr(`PCRB_WIDTH_DETECT_WORD);
         6'd3: script = wr(`PCRB_DUMMY_WORD);
         6'd4: script = wr(`PCRB_SYNC_WORD);
         6'd5: script = wr(`PCRB_NOOP_WORD);
         default: begin
            if (!frame) begin
               unique case (idx)
                  6'd6: script = wr(t1_read_hdr(addr, words));
                  6'd7: script = ctl(PCRB_OP_WRITE, 27'd2);
                  6'd8: script = ctl(PCRB_OP_TURN_READ, 27'd2);
                  6'd9: script = ctl(PCRB_OP_READ, 27'(words));
                  6'd10: script = ctl(PCRB_OP_TURN_WRITE, 27'd2);
                  6'd11: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd12: script = wr(`PCRB_DESYNCHRONIZE_CODE_CODE);
                  6'd13: script = ctl(PCRB_OP_WRITE, 27'd2);
                  default: script = ctl(PCRB_OP_END, 27'd1);
               endcase
            end else begin
               unique case (idx)
                  6'd6: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd7: script = wr(`PCRB_SHUTDOWN_CODE);
                  6'd8: script = wr(`PCRB_NOOP_WORD);
                  6'd9: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd10: script = wr(`PCRB_RESET_CRC_CODE);
                  6'd11: script = wr(`PCRB_NOOP_WORD);
                  6'd12: script = ctl(PCRB_OP_WRITE, `PCRB_SHUTDOWN_NOOPS);
                  6'd13: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd14: script = wr(`PCRB_READ_CONFIG_CODE);
                  6'd15: script = wr(`PCRB_NOOP_WORD);
                  6'd16: script = wr(`PCRB_FAR_WRITE_HDR);
                  6'd17: script = wr(START_FRAME_ADDR);
                  6'd18: script = wr(`PCRB_FRAME_READ0_HDR);
                  6'd19: script = wr(t2_read_hdr(FRAME_READ_WORDS));
                  6'd20: script = ctl(PCRB_OP_WRITE, `PCRB_FLUSH_NOOPS);
                  6'd21: script = ctl(PCRB_OP_TURN_READ, 27'd2);
                  6'd22: script = ctl(PCRB_OP_READ, FRAME_READ_WORDS);
                  6'd23: script = ctl(PCRB_OP_TURN_WRITE, 27'd2);
                  6'd24: script = wr(`PCRB_NOOP_WORD);
                  6'd25: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd26: script = wr(`PCRB_START_CODE);
                  6'd27: script = wr(`PCRB_NOOP_WORD);
                  6'd28: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd29: script = wr(`PCRB_RESET_CRC_CODE);
                  6'd30: script = wr(`PCRB_NOOP_WORD);
                  6'd31: script = wr(`PCRB_CMD_WRITE_HDR);
                  6'd32: script = wr(`PCRB_DESYNCHRONIZE_CODE_CODE);
                  6'd33: script = ctl(PCRB_OP_WRITE, 27'd2);
                  6'd34: script = ctl(PCRB_OP_WAIT_DONE, 27'd1);
                  default: script = ctl(PCRB_OP_END, 27'd1);
               endcase
            end
         end
      endcase
   endfunction : script

   // Pin levels for one beat of a step
   function automatic pcrb_pins_t pins_for(input pcrb_step_t st, input logic [26:0] cnt);
      pins_for = '{chip_select_n: 1'b1, read_write_select: 1'b0, data_oe: 1'b0, data: 32'h00000000};
      unique case (st.op)
         PCRB_OP_WRITE, PCRB_OP_WAIT_DONE: begin
            pins_for = '{chip_select_n: 1'b0, read_write_select: 1'b0, data_oe: 1'b1, data: st.word};
         end
         // Select is high on both beats so the direction never moves while selected
         PCRB_OP_TURN_READ: begin
            pins_for.read_write_select = (cnt != 27'd0);
         end
         PCRB_OP_TURN_WRITE: begin
            pins_for.read_write_select = (cnt == 27'd0);
         end
         PCRB_OP_READ: begin
            pins_for.chip_select_n = 1'b0;
            pins_for.read_write_select = 1'b1;
         end
         PCRB_OP_END: begin
            pins_for.chip_select_n = 1'b1;
         end
      endcase
   endfunction : pins_for

   // ***********************************************************
   // Pin input synchronisers
   // ***********************************************************
   logic [31:0] data_meta;
   logic [31:0] data_sync;
   logic done_meta;
   logic done_sync;

   always_ff @(posedge core_clk_i) begin
      data_meta <= data_i;
      data_sync <= data_meta;
      done_meta <= done_i;
      done_sync <= done_meta;
   end

   // ***********************************************************
   // Sequencer state
   // ***********************************************************
   typedef enum logic [1:0] {PCRB_IDLE, PCRB_RUN} pcrb_state_t;

   pcrb_state_t state;
   logic frame_mode;
   logic [4:0] addr_hold;
   logic [10:0] words_hold;
   logic [5:0] idx;
   logic [26:0] cnt;
   logic spare_valid;
   pcrb_step_t cur;
   logic last_beat;
   logic stall;
   logic rise;
   logic fall;
   logic [5:0] next_idx;
   logic [26:0] next_cnt;
   logic [26:0] word_idx;
   logic capture;
   logic push;
   pcrb_word_t push_word;

   always_comb begin
      cur = script(frame_mode, idx, addr_hold, words_hold);
      unique case (cur.op)
         PCRB_OP_READ: last_beat = (cnt == READ_SKIP + cur.count - 27'd1);
         PCRB_OP_WAIT_DONE: last_beat = done_sync;
         default: last_beat = (cnt == cur.count - 27'd1);
      endcase
      next_idx = last_beat ? idx + 6'd1 : idx;
      next_cnt = last_beat ? 27'd0 : cnt + 27'd1;
   end

   // A full buffer holds the clock low, so the device never runs ahead of the receiver
   assign stall = (cur.op == PCRB_OP_READ) && spare_valid;
   // No beat once the script has reached its end, so the link clock stands still between runs
   assign rise = (state == PCRB_RUN) && (cur.op != PCRB_OP_END) && !config_clock_o && !stall;
   assign fall = config_clock_o;

   // Words before latency and width dummies have passed are not data
   assign word_idx = cnt - READ_SKIP;
   // Taken at the clock fall: a stall before the next rise cannot then change the synchroniser delay
   assign capture = fall && (cur.op == PCRB_OP_READ) && (cnt >= READ_SKIP);
   assign push = capture && !(frame_mode && (word_idx < 27'(WORDS_PER_FRAME)));
   assign push_word = '{data: data_sync, last: (word_idx == cur.count - 27'd1)};

   // ***********************************************************
   // Link clock divider
   // ***********************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         config_clock_o <= 1'b0;
      end else if (rise) begin
         config_clock_o <= 1'b1;
      end else if (fall) begin
         config_clock_o <= 1'b0;
      end
   end

   // ***********************************************************
   // Script walker
   // ***********************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= PCRB_IDLE;
         frame_mode <= 1'b0;
         addr_hold <= `PCRB_STATUS_ADDR;
         words_hold <= `PCRB_STATUS_WORDS;
         idx <= 6'd0;
         cnt <= 27'd0;
         finished_o <= 1'b0;
      end else begin
         finished_o <= 1'b0;
         if (state == PCRB_IDLE) begin
            if (frame_req_i || status_req_i) begin
               state <= PCRB_RUN;
               frame_mode <= frame_req_i;
               addr_hold <= reg_addr_i;
               words_hold <= (reg_words_i == 11'd0) ? `PCRB_STATUS_WORDS : reg_words_i;
               idx <= 6'd0;
               cnt <= 27'd0;
            end
         end else if (cur.op == PCRB_OP_END) begin
            state <= PCRB_IDLE;
            finished_o <= 1'b1;
         end else if (fall) begin
            idx <= next_idx;
            cnt <= next_cnt;
         end
      end
   end

   // ***********************************************************
   // Port pins
   // ***********************************************************
   pcrb_pins_t next_pins;

   always_comb begin
      if (state == PCRB_IDLE) begin
         next_pins = pins_for(script(frame_req_i, 6'd0, reg_addr_i, reg_words_i), 27'd0);
         if (!(frame_req_i || status_req_i)) begin
            next_pins = pins_for(ctl(PCRB_OP_END, 27'd1), 27'd0);
         end
      end else begin
         next_pins = pins_for(script(frame_mode, next_idx, addr_hold, words_hold), next_cnt);
      end
   end

   // Pins move only while the clock is low, a half period before the device samples
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         chip_select_n_o <= 1'b1;
         read_write_select_o <= 1'b0;
         data_oe_o <= 1'b0;
         data_o <= 32'h00000000;
      end else if (state == PCRB_IDLE || fall) begin
         chip_select_n_o <= next_pins.chip_select_n;
         read_write_select_o <= next_pins.read_write_select;
         data_oe_o <= next_pins.data_oe;
         data_o <= next_pins.data;
      end
   end

   // ***********************************************************
   // Status flags
   // ***********************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         done_low_seen_o <= 1'b0;
      end else begin
         busy_o <= (state == PCRB_RUN) && (cur.op != PCRB_OP_END);
         if (state == PCRB_IDLE && (frame_req_i || status_req_i)) begin
            done_low_seen_o <= 1'b0;
         end else if (state == PCRB_RUN && frame_mode && !done_sync) begin
            done_low_seen_o <= 1'b1;
         end
      end
   end

   // ***********************************************************
   // Two-entry read buffer
   // ***********************************************************
   pcrb_word_t spare;
   logic pop;

   assign pop = rd_valid_o && rd_ready_i;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         spare_valid <= 1'b0;
         rd_data_o <= 32'h00000000;
         rd_last_o <= 1'b0;
         spare <= '0;
      end else if (!rd_valid_o || pop) begin
         if (spare_valid) begin
            rd_data_o <= spare.data;
            rd_last_o <= spare.last;
            rd_valid_o <= 1'b1;
            spare_valid <= push;
            spare <= push_word;
         end else begin
            rd_data_o <= push_word.data;
            rd_last_o <= push_word.last;
            rd_valid_o <= push;
         end
      end else if (push) begin
         spare <= push_word;
         spare_valid <= 1'b1;
      end
   end

endmodule : pcrb_host

// *** core/pcrb_params.svh ***
// Constants for the parallel configuration port readback host
`ifndef PCRB_PARAMS_SVH
`define PCRB_PARAMS_SVH

// ***********************************************************
// Packet words
// ***********************************************************
`define PCRB_DUMMY_WORD 32'hffffffff
`define PCRB_WIDTH_SYNC_WORD 32'h000000bb
`define PCRB_WIDTH_DETECT_WORD 32'h11220044
`define PCRB_SYNC_WORD 32'haa995566
`define PCRB_NOOP_WORD 32'h20000000
`define PCRB_FRAME_READ0_HDR 32'h28006000
`define PCRB_CMD_WRITE_HDR 32'h30008001
`define PCRB_FAR_WRITE_HDR 32'h30002001

// ***********************************************************
// Header fields
// ***********************************************************
`define PCRB_T1_TYPE 3'h1
`define PCRB_T2_TYPE 3'h2
`define PCRB_OP_READ 2'h1
`define PCRB_STATUS_ADDR 5'h07
`define PCRB_STATUS_WORDS 11'h001

// ***********************************************************
// Command register codes
// ***********************************************************
`define PCRB_SHUTDOWN_CODE 32'h0000000b
`define PCRB_RESET_CRC_CODE 32'h00000007
`define PCRB_READ_CONFIG_CODE 32'h00000004
`define PCRB_START_CODE 32'h00000005
`define PCRB_DESYNCHRONIZE_CODE_CODE 32'h0000000d

// ***********************************************************
// Counts and timing
// ***********************************************************
`define PCRB_SHUTDOWN_NOOPS 27'd5
`define PCRB_FLUSH_NOOPS 27'd32
`define PCRB_READ_LATENCY 27'd3
`define PCRB_CORE_CLK_NS 40
`define PCRB_CFG_CLK_DIV 2

`endif

// *** core/pcrb_pkg.sv ***
// Types for the parallel configuration port readback host
package pcrb_pkg;

   typedef enum logic [2:0] {
      PCRB_OP_WRITE,
      PCRB_OP_TURN_READ,
      PCRB_OP_READ,
      PCRB_OP_TURN_WRITE,
      PCRB_OP_WAIT_DONE,
      PCRB_OP_END
   } pcrb_op_t;

   typedef struct packed {
      pcrb_op_t op;
      logic [31:0] word;
      logic [26:0] count;
   } pcrb_step_t;

   typedef struct packed {
      logic [31:0] data;
      logic last;
   } pcrb_word_t;

   typedef struct packed {
      logic chip_select_n;
      logic read_write_select;
      logic data_oe;
      logic [31:0] data;
   } pcrb_pins_t;

endpackage : pcrb_pkg

// *** tb/pcrb_dev_model.sv ***
// Behavioural configuration device on the far side of the port
`timescale 1ns/100ps
`include "pcrb_params.svh"
module pcrb_dev_model #(
   parameter int DUMMY = 1
) (
   input wire logic cfg_clk_i,
   input wire logic cs_n_i,
   input wire logic rw_i,
   input wire logic oe_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o,
   output logic done_o
);
   logic [31:0] wlog [0:255];
   int wcount = 0;
   int aborts = 0;
   int rleft = 0;
   int ridx = 0;
   int rbeat = 0;
   int dcnt = 0;
   logic started = 1'b0;
   logic rw_q = 1'b0;
   logic [4:0] raddr = 5'h00;
   logic [31:0] prev = 32'h00000000;
   initial begin
      rdata_o = 32'h5a5a5a5a;
      done_o = 1'b1;
   end
   always @(posedge cfg_clk_i) begin
      if (!cs_n_i && rw_i != rw_q) aborts++;
      rw_q = rw_i;
      if (!cs_n_i && rw_i) begin
         if (oe_i) aborts++;
         if (rbeat >= 2 + DUMMY && ridx < rleft) begin
            rdata_o <= {raddr, 11'h000, ridx[15:0]};
            ridx++;
         end else begin
            rdata_o <= ~rdata_o;
         end
         rbeat++;
      end else begin
         // Released pins toggle so a stale word never looks valid
         rbeat = 0;
         rdata_o <= ~rdata_o;
         if (!cs_n_i) begin
            if (!oe_i) aborts++;
            wlog[wcount[7:0]] = wdata_i;
            wcount++;
            if (wdata_i[31:27] == 5'b00101) begin
               raddr = wdata_i[17:13];
               rleft = int'(wdata_i[10:0]);
               ridx = 0;
            end
            if (wdata_i[31:27] == 5'b01001) rleft = int'(wdata_i[26:0]);
            if (prev == `PCRB_CMD_WRITE_HDR) begin
               if (wdata_i == `PCRB_SHUTDOWN_CODE) done_o <= 1'b0;
               if (wdata_i == `PCRB_START_CODE) started = 1'b1;
               if (wdata_i == `PCRB_DESYNCHRONIZE_CODE_CODE && started) dcnt = 1;
            end else if (dcnt > 0 && wdata_i == `PCRB_NOOP_WORD) begin
               dcnt++;
               if (dcnt > 3) begin
                  done_o <= 1'b1;
                  dcnt = 0;
                  started = 1'b0;
               end
            end
            prev = wdata_i;
         end
      end
   end
endmodule : pcrb_dev_model

// *** tb/pcrb_host_properties.sv ***
// Concurrent checks on the readback host port
`timescale 1ns/100ps
module pcrb_host_props
   import pcrb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic status_req_i,
   input wire logic frame_req_i,
   input wire logic busy_o,
   input wire logic finished_o,
   input wire logic done_low_seen_o,
   input wire logic [31:0] rd_data_o,
   input wire logic rd_last_o,
   input wire logic rd_valid_o,
   input wire logic rd_ready_i,
   input wire logic config_clock_o,
   input wire logic chip_select_n_o,
   input wire logic read_write_select_o,
   input wire logic [31:0] data_o,
   input wire logic data_oe_o,
   input wire logic done_i
);
   logic req_any;
   assign req_any = status_req_i | frame_req_i;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // ***********************************************************
   // Port rules
   // ***********************************************************
   turn_deselect_a: assert property ($changed(read_write_select_o) |-> $past(chip_select_n_o) && chip_select_n_o
      ##1 chip_select_n_o) else $error("direction changed while selected");
   write_drive_a: assert property (!chip_select_n_o && !read_write_select_o |-> data_oe_o)
      else $error("write beat without driving data");
   read_release_a: assert property (!chip_select_n_o && read_write_select_o |-> !data_oe_o)
      else $error("host drives pins in read direction");
   pins_steady_a: assert property ($changed(chip_select_n_o) || $changed(data_o)
      || $changed(read_write_select_o) |-> !config_clock_o) else $error("pins moved at clock rise");
   clk_half_a: assert property ($rose(config_clock_o) |=> $fell(config_clock_o))
      else $error("config clock high too long");
   select_gap_a: assert property ($fell(chip_select_n_o) |-> $stable(read_write_select_o)
      && read_write_select_o == $past(read_write_select_o, 2)) else $error("select too soon after turn");
   busy_cause_a: assert property ($rose(busy_o) |-> $past(req_any, 2) || $past(req_any, 3))
      else $error("busy without request");
   hold_word_a: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o)
      && $stable(rd_last_o)) else $error("read word lost under stall");
   done_track_a: assert property (busy_o && !done_i |-> ##[1:4] done_low_seen_o)
      else $error("done low not reported");
   finish_pulse_a: assert property (finished_o |=> !finished_o)
      else $error("finish not a pulse");
   cover property (finished_o && !done_low_seen_o);
   cover property (finished_o && done_low_seen_o);
   cover property (rd_valid_o && !rd_ready_i ##1 rd_valid_o);
   cover property (!chip_select_n_o && read_write_select_o && config_clock_o);
endmodule : pcrb_host_props

bind pcrb_host pcrb_host_props chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .status_req_i(status_req_i),
   .frame_req_i(frame_req_i), .busy_o(busy_o), .finished_o(finished_o), .done_low_seen_o(done_low_seen_o),
   .rd_data_o(rd_data_o), .rd_last_o(rd_last_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
   .config_clock_o(config_clock_o), .chip_select_n_o(chip_select_n_o),
   .read_write_select_o(read_write_select_o), .data_o(data_o), .data_oe_o(data_oe_o), .done_i(done_i));

// *** tb/testbench.sv ***
// Self-checking bench for the parallel port readback host
`timescale 1ns/100ps
`include "pcrb_params.svh"
module testbench;
   import pcrb_pkg::*;
   localparam logic [15:0] WPF = 16'h0004;
   localparam logic [10:0] NFR = 11'h002;
   localparam logic [31:0] FADDR = 32'h00000003;
   localparam logic [31:0] NOOP = `PCRB_NOOP_WORD;
   localparam logic [31:0] CMD = `PCRB_CMD_WRITE_HDR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic st_req = 1'b0;
   logic fr_req = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [10:0] words = 11'h000;
   logic busy, fin, dls, rlast, rvalid, config_clock, csn, rw, oe, done;
   logic rready = 1'b1;
   logic stall = 1'b0;
   logic [31:0] rdata, wdata, pins;
   logic [32:0] got [$];
   logic [31:0] exp_q [$];
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   int base = 0;
   pcrb_host #(.WORDS_PER_FRAME(WPF), .FRAME_COUNT(NFR), .START_FRAME_ADDR(FADDR), .READ_DUMMY_WORDS(4'h1)) dut (
      .core_clk_i(clk), .rst_i(rst), .status_req_i(st_req), .frame_req_i(fr_req), .reg_addr_i(addr),
      .reg_words_i(words), .busy_o(busy), .finished_o(fin), .done_low_seen_o(dls), .rd_data_o(rdata),
      .rd_last_o(rlast), .rd_valid_o(rvalid), .rd_ready_i(rready), .config_clock_o(config_clock),
      .chip_select_n_o(csn), .read_write_select_o(rw), .data_o(wdata), .data_oe_o(oe), .data_i(pins),
      .done_i(done));
   pcrb_dev_model #(.DUMMY(1)) dev (.cfg_clk_i(config_clock), .cs_n_i(csn), .rw_i(rw), .oe_i(oe), .wdata_i(wdata),
      .rdata_o(pins), .done_o(done));
   always #20 clk = ~clk;
   // Receiver stalls most cycles so the two-entry buffer fills and the link must stop
   always @(negedge clk) begin
      cyc++;
      rready <= !stall || cyc % 6 == 0;
   end
   always @(posedge clk) if (rvalid && rready) got.push_back({rlast, rdata});
   // ***********************************************************
   // Helpers
   // ***********************************************************
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [32:0] g, input logic [32:0] e, input string msg);
      n_compared++;
      if (g !== e) $display("mismatch at %0t: %s got %h want %h", $time, msg, g, e);
      if (g !== e) n_fail++;
   endtask : chk
   task automatic e(input logic [31:0] w, input int n);
      repeat (n) exp_q.push_back(w);
   endtask : e
   function automatic logic [31:0] hdr(input logic [4:0] a, input logic [10:0] n);
      return {3'h1, 2'h1, 9'h000, a, 2'h0, n};
   endfunction : hdr
   task automatic session();
      exp_q = {};
      e(32'hffffffff, 1);
      e(32'h000000bb, 1);
      e(32'h11220044, 1);
      e(32'hffffffff, 1);
      e(32'haa995566, 1);
      e(NOOP, 1);
   endtask : session
   task automatic run(input logic fr, input logic [4:0] a, input logic [10:0] n);
      int k;
      base = dev.wcount;
      got = {};
      k = 0;
      @(negedge clk);
      fr_req <= fr;
      st_req <= !fr;
      addr <= a;
      words <= n;
      @(negedge clk);
      fr_req <= 1'b0;
      st_req <= 1'b0;
      while (fin !== 1'b1 && k < 20000) begin
         @(negedge clk);
         k++;
         // A request while busy must be ignored
         if (k == 50) st_req <= fr;
         if (k == 51) st_req <= 1'b0;
      end
      if (k >= 20000) begin
         n_fail++;
         $display("mismatch at %0t: run timed out", $time);
         report_and_stop();
      end
      repeat (4) @(negedge clk);
      foreach (exp_q[i]) chk({1'b0, dev.wlog[base + i]}, {1'b0, exp_q[i]}, "written word");
      chk(33'(dev.aborts), 33'h0, "abort seen");
   endtask : run
   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic test_status();
      session();
      e(32'h2800e001, 1);
      e(NOOP, 2);
      e(CMD, 1);
      e(`PCRB_DESYNCHRONIZE_CODE_CODE, 1);
      e(NOOP, 2);
      run(1'b0, 5'h07, 11'h001);
      chk(33'(dev.wcount - base), 33'(exp_q.size()), "status write count");
      chk(33'(got.size()), 33'h1, "status word count");
      chk(got[0], {1'b1, 5'h07, 27'h0}, "status word");
      $display("test status_read ended");
   endtask : test_status
   task automatic test_other();
      stall = 1'b1;
      session();
      e(hdr(5'h0a, 11'h003), 1);
      run(1'b0, 5'h0a, 11'h003);
      chk(33'(got.size()), 33'h3, "register word count");
      foreach (got[i]) chk(got[i], {i == 2, 5'h0a, 11'h000, 16'(i)}, "register word");
      $display("test other_register ended");
   endtask : test_other
   task automatic test_frame();
      int n;
      session();
      e(CMD, 1);
      e(`PCRB_SHUTDOWN_CODE, 1);
      e(NOOP, 1);
      e(CMD, 1);
      e(`PCRB_RESET_CRC_CODE, 1);
      e(NOOP, 6);
      e(CMD, 1);
      e(`PCRB_READ_CONFIG_CODE, 1);
      e(NOOP, 1);
      e(32'h30002001, 1);
      e(FADDR, 1);
      e(32'h28006000, 1);
      e({3'h2, 2'h1, 27'(WPF) * 27'(NFR + 11'h001)}, 1);
      e(NOOP, 33);
      e(CMD, 1);
      e(`PCRB_START_CODE, 1);
      e(NOOP, 1);
      e(CMD, 1);
      e(`PCRB_RESET_CRC_CODE, 1);
      e(NOOP, 1);
      e(CMD, 1);
      e(`PCRB_DESYNCHRONIZE_CODE_CODE, 1);
      e(NOOP, 2);
      run(1'b1, 5'h00, 11'h000);
      for (int i = base + 67; i < dev.wcount; i++) chk({1'b0, dev.wlog[i]}, {1'b0, NOOP}, "tail word");
      chk(33'(got.size()), 33'h8, "frame word count");
      foreach (got[i]) chk(got[i], {i == 7, 5'h03, 11'h000, 16'(i + 4)}, "frame word");
      chk({32'h0, dls}, 33'h1, "done low flag");
      n = dev.wcount;
      repeat (10) @(negedge clk);
      chk({32'h0, busy}, 33'h0, "refused request started");
      chk(33'(dev.wcount), 33'(n), "refused request wrote");
      stall = 1'b0;
      $display("test frame_read ended");
   endtask : test_frame
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst <= 1'b0;
      test_status();
      test_other();
      test_frame();
      report_and_stop();
   end
endmodule : testbench
